// *** mir_pkg.sv ***
package mir_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_AUX_ENABLE = 8'hA7;
  localparam logic [7:0] IDX_MAIN_ENABLE = 8'hA8;
  localparam logic [7:0] IDX_AUX_LEVEL = 8'hB7;
  localparam logic [7:0] IDX_MAIN_LEVEL = 8'hB8;
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] IDX_TIMER_C_CONTROL = 8'hC8;
  localparam logic [7:0] IDX_SOURCE_CONFIG = 8'hC0;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'hC1;
  localparam logic [7:0] IDX_EVENT_MASK = 8'hC2;
  localparam logic [7:0] IDX_SERVICE_STATE = 8'hC3;
  localparam int ADDR_W = 12;
  localparam logic [7:0] RESET_VAL = 8'h00;
  // Implemented bits; the rest read as zero
  localparam logic [7:0] AUX_BITS = 8'h13;
  localparam logic [7:0] MAIN_EN_BITS = 8'hBF;
  localparam logic [7:0] MAIN_LVL_BITS = 8'h3F;
  localparam logic [7:0] TC_BITS = 8'hAF;
  localparam logic [7:0] TCC_BITS = 8'hC8;
  localparam logic [7:0] CFG_BITS = 8'h01;
  localparam logic [7:0] EVT_BITS = 8'h07;
  // Main enable / level fields
  localparam int M_EXT_A = 0;
  localparam int M_TMR_A = 1;
  localparam int M_EXT_B = 2;
  localparam int M_TMR_B = 3;
  localparam int M_SER_ONE = 4;
  localparam int M_TMR_C = 5;
  localparam int M_GLOBAL = 7;
  // Auxiliary enable / level fields
  localparam int A_USB = 0;
  localparam int A_TWOWIRE = 1;
  localparam int A_SER_TWO = 4;
  // Timer control fields
  localparam int TC_EXT_A_SEL = 0;
  localparam int TC_EXT_A_FLAG = 1;
  localparam int TC_EXT_B_SEL = 2;
  localparam int TC_EXT_B_FLAG = 3;
  localparam int TC_TMR_A_OVF = 5;
  localparam int TC_TMR_B_OVF = 7;
  // Timer c control fields and source config field
  localparam int TCC_TRIG_EN = 3;
  localparam int TCC_TRIG_FLAG = 6;
  localparam int TCC_OVF = 7;
  localparam int CFG_ADC_TAKEOVER = 0;
  // Event status fields
  localparam int EV_HIGH_TAKEN = 0;
  localparam int EV_LOW_TAKEN = 1;
  localparam int EV_STRAY_RETURN = 2;
  // Sources in polling order, 0 first
  localparam int NSRC = 10;
  localparam logic [3:0] SRC_EXT_A = 4'h0;
  localparam logic [3:0] SRC_SER_TWO = 4'h1;
  localparam logic [3:0] SRC_TMR_A = 4'h2;
  localparam logic [3:0] SRC_TWOWIRE = 4'h3;
  localparam logic [3:0] SRC_EXT_B = 4'h4;
  localparam logic [3:0] SRC_RESERVED = 4'h5;
  localparam logic [3:0] SRC_TMR_B = 4'h6;
  localparam logic [3:0] SRC_USB = 4'h7;
  localparam logic [3:0] SRC_SER_ONE = 4'h8;
  localparam logic [3:0] SRC_TMR_C = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Request offered to the core sequencer
  typedef struct packed {
    logic valid;
    logic high;
    logic [3:0] source;
  } mir_request_t;
endpackage

// *** mir_irq_ctrl.sv ***
`timescale 1ns/10ps
// Operation
// - Nine request sources feed ten polling slots
// - External A edge or level, flag requests
// - External B edge or level, flag requests
// - Edge flags cleared on vectoring or by write
// - Level flag follows pin every cycle, even when taken
// - Timer A/B overflow flags, A not in mode 3
// - Timer A/B flags cleared on vectoring
// - Timer C overflow flag, software clear only
// - Timer C trigger pin, enable and flag
// - Two-wire request bit, cleared by unit
// - Converter may take over external B
// - USB request from its event flags
// - Serial request is receive OR transmit
// - Second serial port uses aux bit 4
// - Per-source enables plus global enable
// - Two levels; high preempts low only
// - Fixed polling order within a level
module mir_irq_ctrl (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_request_a_n,
  input wire logic external_request_b_n,
  input wire logic adc_conversion_done,
  input wire logic timer_a_overflow,
  input wire logic timer_a_mode3,
  input wire logic timer_b_overflow,
  input wire logic timer_c_overflow,
  input wire logic timer_c_trigger_pin,
  input wire logic twowire_request_bit,
  input wire logic usb_request,
  input wire logic serial_one_receive_done_flag,
  input wire logic serial_one_transmit_done_flag,
  input wire logic serial_two_receive_done_flag,
  input wire logic serial_two_transmit_done_flag,
  output mir_pkg::mir_request_t core_request,
  input wire logic vector_ack,
  input wire logic [3:0] vector_source,
  input wire logic service_return,
  output logic irq
);
  logic aw_ready_reg, w_ready_reg, b_valid_reg;
  logic ar_ready_reg, r_valid_reg;
  logic [31:0] r_data_reg;
  logic [1:0] b_resp_reg, r_resp_reg;
  logic [7:0] aux_enable_reg, main_enable_reg;
  logic [7:0] aux_level_reg, main_level_reg;
  logic [7:0] config_reg, event_mask_reg, event_status_reg;
  logic [7:0] event_status_next;
  logic ext_a_edge_select, ext_b_edge_select, timer_c_trigger_enable;
  logic ext_a_request_flag, ext_b_request_flag;
  logic timer_a_overflow_flag, timer_b_overflow_flag;
  logic timer_c_overflow_flag, timer_c_trigger_flag;
  logic line_a_prev_reg, line_b_prev_reg, trig_prev_reg;
  logic in_high_reg, in_low_reg, irq_reg;
  mir_pkg::mir_request_t request_reg, request_next;
  logic wr_go, wr_tc, wr_tcc, wr_mask, wr_hit;
  logic [7:0] wr_idx, rd_idx, wr_byte, rd_val;
  logic rd_hit;
  logic line_a, line_b, set_a, set_b, set_trig;
  logic [mir_pkg::NSRC-1:0] req_vec, en_vec, lvl_vec;
  logic [mir_pkg::NSRC-1:0] hi_cand, lo_cand;
  logic ack_high, clr_a, clr_b, clr_ta, clr_tb;

  // Flag update where a hardware set always wins
  function automatic logic flag_upd(input logic cur, input logic set,
      input logic hw_clr, input logic wr, input logic wbit);
    flag_upd = set | (wr ? wbit : (cur & ~hw_clr));
  endfunction

  // Lowest-numbered set bit in polling order
  function automatic logic [3:0] first_src(
      input logic [mir_pkg::NSRC-1:0] v);
    first_src = 4'h0;
    for (int i = mir_pkg::NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_src = 4'(i);
      end
    end
  endfunction

  // Bus decode
  assign wr_go = aw_ready_reg & w_ready_reg;
  assign wr_idx = s_axi_awaddr[9:2];
  assign rd_idx = s_axi_araddr[9:2];
  assign wr_byte = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
  assign wr_hit = (s_axi_awaddr[11:10] == 2'h0) &&
      (wr_idx == mir_pkg::IDX_AUX_ENABLE ||
       wr_idx == mir_pkg::IDX_MAIN_ENABLE ||
       wr_idx == mir_pkg::IDX_AUX_LEVEL ||
       wr_idx == mir_pkg::IDX_MAIN_LEVEL ||
       wr_idx == mir_pkg::IDX_TIMER_CONTROL ||
       wr_idx == mir_pkg::IDX_TIMER_C_CONTROL ||
       wr_idx == mir_pkg::IDX_SOURCE_CONFIG ||
       wr_idx == mir_pkg::IDX_EVENT_STATUS ||
       wr_idx == mir_pkg::IDX_EVENT_MASK ||
       wr_idx == mir_pkg::IDX_SERVICE_STATE);
  assign wr_tc = wr_go && s_axi_wstrb[0] &&
      wr_idx == mir_pkg::IDX_TIMER_CONTROL && wr_hit;
  assign wr_tcc = wr_go && s_axi_wstrb[0] &&
      wr_idx == mir_pkg::IDX_TIMER_C_CONTROL && wr_hit;
  assign wr_mask = wr_go && s_axi_wstrb[0] &&
      wr_idx == mir_pkg::IDX_EVENT_MASK && wr_hit;

  // Write channel: address and data taken together
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_ready_reg <= 1'b0;
      w_ready_reg <= 1'b0;
      b_valid_reg <= 1'b0;
      b_resp_reg <= mir_pkg::RESP_OKAY;
    end else begin
      aw_ready_reg <= 1'b0;
      w_ready_reg <= 1'b0;
      if (wr_go) begin
        b_valid_reg <= 1'b1;
        b_resp_reg <= wr_hit ? mir_pkg::RESP_OKAY : mir_pkg::RESP_DECERR;
      end else if (b_valid_reg && s_axi_bready) begin
        b_valid_reg <= 1'b0;
      end else if (!b_valid_reg && !aw_ready_reg &&
          s_axi_awvalid && s_axi_wvalid) begin
        aw_ready_reg <= 1'b1;
        w_ready_reg <= 1'b1;
      end
    end
  end

  // Read data mux
  always_comb begin
    rd_hit = s_axi_araddr[11:10] == 2'h0;
    rd_val = 8'h00;
    if (rd_idx == mir_pkg::IDX_AUX_ENABLE) begin
      rd_val = aux_enable_reg;
    end else if (rd_idx == mir_pkg::IDX_MAIN_ENABLE) begin
      rd_val = main_enable_reg;
    end else if (rd_idx == mir_pkg::IDX_AUX_LEVEL) begin
      rd_val = aux_level_reg;
    end else if (rd_idx == mir_pkg::IDX_MAIN_LEVEL) begin
      rd_val = main_level_reg;
    end else if (rd_idx == mir_pkg::IDX_TIMER_CONTROL) begin
      rd_val[mir_pkg::TC_EXT_A_SEL] = ext_a_edge_select;
      rd_val[mir_pkg::TC_EXT_A_FLAG] = ext_a_request_flag;
      rd_val[mir_pkg::TC_EXT_B_SEL] = ext_b_edge_select;
      rd_val[mir_pkg::TC_EXT_B_FLAG] = ext_b_request_flag;
      rd_val[mir_pkg::TC_TMR_A_OVF] = timer_a_overflow_flag;
      rd_val[mir_pkg::TC_TMR_B_OVF] = timer_b_overflow_flag;
    end else if (rd_idx == mir_pkg::IDX_TIMER_C_CONTROL) begin
      rd_val[mir_pkg::TCC_TRIG_EN] = timer_c_trigger_enable;
      rd_val[mir_pkg::TCC_TRIG_FLAG] = timer_c_trigger_flag;
      rd_val[mir_pkg::TCC_OVF] = timer_c_overflow_flag;
    end else if (rd_idx == mir_pkg::IDX_SOURCE_CONFIG) begin
      rd_val = config_reg;
    end else if (rd_idx == mir_pkg::IDX_EVENT_STATUS) begin
      rd_val = event_status_reg;
    end else if (rd_idx == mir_pkg::IDX_EVENT_MASK) begin
      rd_val = event_mask_reg;
    end else if (rd_idx == mir_pkg::IDX_SERVICE_STATE) begin
      rd_val = {in_high_reg, in_low_reg, request_reg};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ar_ready_reg <= 1'b0;
      r_valid_reg <= 1'b0;
      r_data_reg <= 32'h0000_0000;
      r_resp_reg <= mir_pkg::RESP_OKAY;
    end else begin
      ar_ready_reg <= 1'b0;
      if (ar_ready_reg) begin
        r_valid_reg <= 1'b1;
        r_data_reg <= {24'h00_0000, rd_val};
        r_resp_reg <= rd_hit ? mir_pkg::RESP_OKAY : mir_pkg::RESP_DECERR;
      end else if (r_valid_reg && s_axi_rready) begin
        r_valid_reg <= 1'b0;
      end else if (!r_valid_reg && s_axi_arvalid) begin
        ar_ready_reg <= 1'b1;
      end
    end
  end

  // Enable, level and configuration registers; reserved bits held zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aux_enable_reg <= mir_pkg::RESET_VAL;
      main_enable_reg <= mir_pkg::RESET_VAL;
      aux_level_reg <= mir_pkg::RESET_VAL;
      main_level_reg <= mir_pkg::RESET_VAL;
      config_reg <= mir_pkg::RESET_VAL;
      event_mask_reg <= mir_pkg::RESET_VAL;
      ext_a_edge_select <= 1'b0;
      ext_b_edge_select <= 1'b0;
      timer_c_trigger_enable <= 1'b0;
    end else if (wr_go && s_axi_wstrb[0] && wr_hit) begin
      unique case (wr_idx)
        mir_pkg::IDX_AUX_ENABLE: begin
          aux_enable_reg <= wr_byte & mir_pkg::AUX_BITS;
        end
        mir_pkg::IDX_MAIN_ENABLE: begin
          main_enable_reg <= wr_byte & mir_pkg::MAIN_EN_BITS;
        end
        mir_pkg::IDX_AUX_LEVEL: begin
          aux_level_reg <= wr_byte & mir_pkg::AUX_BITS;
        end
        mir_pkg::IDX_MAIN_LEVEL: begin
          main_level_reg <= wr_byte & mir_pkg::MAIN_LVL_BITS;
        end
        mir_pkg::IDX_TIMER_CONTROL: begin
          ext_a_edge_select <= wr_byte[mir_pkg::TC_EXT_A_SEL];
          ext_b_edge_select <= wr_byte[mir_pkg::TC_EXT_B_SEL];
        end
        mir_pkg::IDX_TIMER_C_CONTROL: begin
          timer_c_trigger_enable <= wr_byte[mir_pkg::TCC_TRIG_EN];
        end
        mir_pkg::IDX_SOURCE_CONFIG: begin
          config_reg <= wr_byte & mir_pkg::CFG_BITS;
        end
        mir_pkg::IDX_EVENT_MASK: begin
          event_mask_reg <= wr_byte & mir_pkg::EVT_BITS;
        end
        default: begin
        end
      endcase
    end
  end

  // External lines; converter may replace line B
  assign line_a = ~external_request_a_n;
  assign line_b = config_reg[mir_pkg::CFG_ADC_TAKEOVER] ?
      adc_conversion_done : ~external_request_b_n;
  assign set_a = ext_a_edge_select ? (line_a & ~line_a_prev_reg) : 1'b0;
  assign set_b = ext_b_edge_select ? (line_b & ~line_b_prev_reg) : 1'b0;
  assign set_trig = timer_c_trigger_enable & ~timer_c_trigger_pin &
      trig_prev_reg;
  // Out-of-range source codes count as low level
  assign ack_high = (vector_source < 4'(mir_pkg::NSRC)) &&
      lvl_vec[vector_source];
  assign clr_a = vector_ack && vector_source == mir_pkg::SRC_EXT_A;
  assign clr_b = vector_ack && vector_source == mir_pkg::SRC_EXT_B;
  assign clr_ta = vector_ack && vector_source == mir_pkg::SRC_TMR_A;
  assign clr_tb = vector_ack && vector_source == mir_pkg::SRC_TMR_B;

  // Previous line samples for edge detection
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_a_prev_reg <= 1'b0;
      line_b_prev_reg <= 1'b0;
      trig_prev_reg <= 1'b1;
    end else begin
      line_a_prev_reg <= line_a;
      line_b_prev_reg <= line_b;
      trig_prev_reg <= timer_c_trigger_pin;
    end
  end

  // External request flags
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_a_request_flag <= 1'b0;
      ext_b_request_flag <= 1'b0;
    end else begin
      if (ext_a_edge_select) begin
        ext_a_request_flag <= flag_upd(ext_a_request_flag, set_a,
            clr_a, wr_tc, wr_byte[mir_pkg::TC_EXT_A_FLAG]);
      end else begin
        ext_a_request_flag <= line_a;
      end
      if (ext_b_edge_select) begin
        ext_b_request_flag <= flag_upd(ext_b_request_flag, set_b,
            clr_b, wr_tc, wr_byte[mir_pkg::TC_EXT_B_FLAG]);
      end else begin
        ext_b_request_flag <= line_b;
      end
    end
  end

  // Timer flags
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_a_overflow_flag <= 1'b0;
      timer_b_overflow_flag <= 1'b0;
      timer_c_overflow_flag <= 1'b0;
      timer_c_trigger_flag <= 1'b0;
    end else begin
      timer_a_overflow_flag <= flag_upd(timer_a_overflow_flag,
          timer_a_overflow & ~timer_a_mode3, clr_ta,
          wr_tc, wr_byte[mir_pkg::TC_TMR_A_OVF]);
      timer_b_overflow_flag <= flag_upd(timer_b_overflow_flag,
          timer_b_overflow, clr_tb,
          wr_tc, wr_byte[mir_pkg::TC_TMR_B_OVF]);
      timer_c_overflow_flag <= flag_upd(timer_c_overflow_flag,
          timer_c_overflow, 1'b0,
          wr_tcc, wr_byte[mir_pkg::TCC_OVF]);
      timer_c_trigger_flag <= flag_upd(timer_c_trigger_flag,
          set_trig, 1'b0,
          wr_tcc, wr_byte[mir_pkg::TCC_TRIG_FLAG]);
    end
  end

  // Source requests in polling order
  always_comb begin
    req_vec = '0;
    req_vec[mir_pkg::SRC_EXT_A] = ext_a_request_flag;
    req_vec[mir_pkg::SRC_SER_TWO] = serial_two_receive_done_flag |
        serial_two_transmit_done_flag;
    req_vec[mir_pkg::SRC_TMR_A] = timer_a_overflow_flag;
    req_vec[mir_pkg::SRC_TWOWIRE] = twowire_request_bit;
    req_vec[mir_pkg::SRC_EXT_B] = ext_b_request_flag;
    req_vec[mir_pkg::SRC_TMR_B] = timer_b_overflow_flag;
    req_vec[mir_pkg::SRC_USB] = usb_request;
    req_vec[mir_pkg::SRC_SER_ONE] = serial_one_receive_done_flag |
        serial_one_transmit_done_flag;
    req_vec[mir_pkg::SRC_TMR_C] = timer_c_overflow_flag |
        timer_c_trigger_flag;
  end

  // Per-source enable and level maps; reserved slot stays zero
  always_comb begin
    en_vec = '0;
    lvl_vec = '0;
    en_vec[mir_pkg::SRC_EXT_A] = main_enable_reg[mir_pkg::M_EXT_A];
    en_vec[mir_pkg::SRC_SER_TWO] = aux_enable_reg[mir_pkg::A_SER_TWO];
    en_vec[mir_pkg::SRC_TMR_A] = main_enable_reg[mir_pkg::M_TMR_A];
    en_vec[mir_pkg::SRC_TWOWIRE] = aux_enable_reg[mir_pkg::A_TWOWIRE];
    en_vec[mir_pkg::SRC_EXT_B] = main_enable_reg[mir_pkg::M_EXT_B];
    en_vec[mir_pkg::SRC_TMR_B] = main_enable_reg[mir_pkg::M_TMR_B];
    en_vec[mir_pkg::SRC_USB] = aux_enable_reg[mir_pkg::A_USB];
    en_vec[mir_pkg::SRC_SER_ONE] = main_enable_reg[mir_pkg::M_SER_ONE];
    en_vec[mir_pkg::SRC_TMR_C] = main_enable_reg[mir_pkg::M_TMR_C];
    lvl_vec[mir_pkg::SRC_EXT_A] = main_level_reg[mir_pkg::M_EXT_A];
    lvl_vec[mir_pkg::SRC_SER_TWO] = aux_level_reg[mir_pkg::A_SER_TWO];
    lvl_vec[mir_pkg::SRC_TMR_A] = main_level_reg[mir_pkg::M_TMR_A];
    lvl_vec[mir_pkg::SRC_TWOWIRE] = aux_level_reg[mir_pkg::A_TWOWIRE];
    lvl_vec[mir_pkg::SRC_EXT_B] = main_level_reg[mir_pkg::M_EXT_B];
    lvl_vec[mir_pkg::SRC_TMR_B] = main_level_reg[mir_pkg::M_TMR_B];
    lvl_vec[mir_pkg::SRC_USB] = aux_level_reg[mir_pkg::A_USB];
    lvl_vec[mir_pkg::SRC_SER_ONE] = main_level_reg[mir_pkg::M_SER_ONE];
    lvl_vec[mir_pkg::SRC_TMR_C] = main_level_reg[mir_pkg::M_TMR_C];
  end

  // Candidate sets per level
  assign hi_cand = req_vec & en_vec & lvl_vec &
      {mir_pkg::NSRC{main_enable_reg[mir_pkg::M_GLOBAL]}};
  assign lo_cand = req_vec & en_vec & ~lvl_vec &
      {mir_pkg::NSRC{main_enable_reg[mir_pkg::M_GLOBAL]}};

  // Selection: high first, preemption limited by service state
  always_comb begin
    request_next = '0;
    if (vector_ack || service_return || in_high_reg) begin
      request_next = '0;
    end else if (|hi_cand) begin
      request_next.valid = 1'b1;
      request_next.high = 1'b1;
      request_next.source = first_src(hi_cand);
    end else if (|lo_cand && !in_low_reg) begin
      request_next.valid = 1'b1;
      request_next.source = first_src(lo_cand);
    end
  end

  // Request register and service levels in progress
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      request_reg <= '0;
      in_high_reg <= 1'b0;
      in_low_reg <= 1'b0;
    end else begin
      request_reg <= request_next;
      if (vector_ack) begin
        if (ack_high) begin
          in_high_reg <= 1'b1;
        end else begin
          in_low_reg <= 1'b1;
        end
      end else if (service_return) begin
        if (in_high_reg) begin
          in_high_reg <= 1'b0;
        end else begin
          in_low_reg <= 1'b0;
        end
      end
    end
  end

  // Event status: set wins over write-one clear
  always_comb begin
    event_status_next = event_status_reg;
    if (wr_go && s_axi_wstrb[0] && wr_hit &&
        wr_idx == mir_pkg::IDX_EVENT_STATUS) begin
      event_status_next = event_status_reg & ~wr_byte;
    end
    event_status_next[mir_pkg::EV_HIGH_TAKEN] =
        event_status_next[mir_pkg::EV_HIGH_TAKEN] | (vector_ack & ack_high);
    event_status_next[mir_pkg::EV_LOW_TAKEN] =
        event_status_next[mir_pkg::EV_LOW_TAKEN] | (vector_ack & ~ack_high);
    event_status_next[mir_pkg::EV_STRAY_RETURN] =
        event_status_next[mir_pkg::EV_STRAY_RETURN] |
        (service_return & ~vector_ack & ~in_high_reg & ~in_low_reg);
  end

  // Status register and interrupt line
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      event_status_reg <= mir_pkg::RESET_VAL;
      irq_reg <= 1'b0;
    end else begin
      event_status_reg <= event_status_next;
      irq_reg <= |(event_status_next & event_mask_reg);
    end
  end

  // Port drivers
  assign s_axi_awready = aw_ready_reg;
  assign s_axi_wready = w_ready_reg;
  assign s_axi_bvalid = b_valid_reg;
  assign s_axi_bresp = b_resp_reg;
  assign s_axi_arready = ar_ready_reg;
  assign s_axi_rvalid = r_valid_reg;
  assign s_axi_rdata = r_data_reg;
  assign s_axi_rresp = r_resp_reg;
  assign core_request = request_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_stray_ret;
    service_return && !vector_ack && !in_high_reg && !in_low_reg &&
        event_mask_reg[mir_pkg::EV_STRAY_RETURN] && !wr_mask;
  endsequence
  sequence s_low_taken;
    vector_ack && !ack_high && event_mask_reg[mir_pkg::EV_LOW_TAKEN];
  endsequence

  a_global_gate: assert property (
    !main_enable_reg[mir_pkg::M_GLOBAL] |=> !core_request.valid)
    else $error("request offered while globally disabled");
  a_high_no_preempt: assert property (
    in_high_reg |=> !core_request.valid)
    else $error("request offered during high service");
  a_low_preempt_high: assert property (
    in_low_reg && core_request.valid |-> core_request.high)
    else $error("low request offered during low service");
  a_edge_ack_clear: assert property (
    clr_a && ext_a_edge_select && !set_a && !wr_tc
        |=> !ext_a_request_flag)
    else $error("edge flag A not cleared on vectoring");
  a_level_follows: assert property (
    !ext_b_edge_select |=> ext_b_request_flag == $past(line_b))
    else $error("level flag B does not follow line");
  a_tmr_c_sticky: assert property (
    timer_c_overflow_flag && !wr_tcc |=> timer_c_overflow_flag)
    else $error("timer C flag cleared without software");
  a_tmr_a_clear: assert property (
    clr_ta && !timer_a_overflow && !wr_tc |=> !timer_a_overflow_flag)
    else $error("timer A flag not cleared on vectoring");
  a_stray_irq: assert property (
    s_stray_ret |=> irq)
    else $error("stray return did not raise interrupt");
  a_taken_irq: assert property (
    s_low_taken |=> irq)
    else $error("low vector taken did not raise interrupt");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
endmodule

// *** mir_core_model.sv ***
`timescale 1ns/10ps
// Core sequencer stand-in: vectors one request, returns after service
module mir_core_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire mir_pkg::mir_request_t core_request,
  output logic vector_ack,
  output logic [3:0] vector_source,
  output logic service_return
);
  logic [2:0] busy_reg;
  // Ack when idle, count down the service, then pulse the return
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      vector_ack <= 1'b0;
      vector_source <= 4'h0;
      service_return <= 1'b0;
      busy_reg <= 3'h0;
    end else begin
      vector_ack <= 1'b0;
      service_return <= busy_reg == 3'h1;
      vector_source <= ~vector_source; // Junk between acks
      if (busy_reg != 3'h0) begin
        busy_reg <= busy_reg - 3'h1;
      end else if (run && core_request.valid) begin
        vector_ack <= 1'b1;
        vector_source <= core_request.source;
        busy_reg <= 3'h6;
      end
    end
  end
endmodule

// *** mir_irq_ctrl_tb_top.sv ***
`timescale 1ns/10ps
module mir_irq_ctrl_tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, run = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_bvalid, s_axi_rvalid;
  logic s_axi_awready, s_axi_wready, s_axi_arready, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic external_request_a_n, external_request_b_n, adc_conversion_done;
  logic timer_a_overflow, timer_a_mode3, timer_b_overflow, timer_c_overflow;
  logic timer_c_trigger_pin, twowire_request_bit, usb_request;
  logic serial_one_receive_done_flag, serial_one_transmit_done_flag;
  logic serial_two_receive_done_flag, serial_two_transmit_done_flag;
  logic vector_ack, service_return;
  logic [3:0] vector_source, s;
  logic [9:0] req;
  logic [7:0] d;
  mir_pkg::mir_request_t core_request;
  int fail_count = 0, n_compared = 0, cyc = 0;
  mir_irq_ctrl i_mir_irq_ctrl (.*);
  mir_core_model i_mir_core_model (.*);
  always #10 core_clk = ~core_clk;
  // Cut a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
  end
  // All request sources at once; pins idle high
  task automatic srcs(input logic [13:0] v);
    {external_request_a_n, external_request_b_n, adc_conversion_done,
     timer_a_overflow, timer_a_mode3, timer_b_overflow, timer_c_overflow,
     timer_c_trigger_pin, twowire_request_bit, usb_request,
     serial_one_receive_done_flag, serial_one_transmit_done_flag,
     serial_two_receive_done_flag, serial_two_transmit_done_flag} <= v;
  endtask
  // One register write or read
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    s_axi_awaddr <= {2'h0, a, 2'h0};
    s_axi_araddr <= {2'h0, a, 2'h0};
    s_axi_wdata <= {24'h0, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do @(negedge core_clk); while ((w ? s_axi_awready : s_axi_arready) !== 1);
    @(posedge core_clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    do @(negedge core_clk); while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1);
    q = s_axi_rdata;
    r = w ? s_axi_bresp : s_axi_rresp;
    @(posedge core_clk);
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // First set source in polling order
  function automatic logic [3:0] pick(input logic [9:0] v);
    pick = 4'hF;
    for (int i = 9; i >= 0; i--) if (v[i]) pick = i[3:0];
  endfunction
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  logic [7:0] idx[4] = '{8'hA7, 8'hA8, 8'hB7, 8'hB8};
  logic [7:0] msk[4] = '{8'h13, 8'hBF, 8'h13, 8'h3F};
  initial begin
    srcs(14'h3000);
    void'($urandom(54));
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    // Reset values, random writes, reserved bits read zero
    for (int i = 0; i < 4; i++) begin
      bus(0, idx[i], 8'h00);
      chk(q, 32'h0, "reset");
      d = $urandom;
      bus(1, idx[i], d);
      chk(r, 32'h0, "bresp");
      bus(0, idx[i], 8'h00);
      chk(q, {24'h0, d & msk[i]}, "readback");
      bus(1, idx[i], i[0] ? 8'hBF : 8'h13);
    end
    bus(0, 8'h10, 8'h00);
    chk({q[29:0], r}, 32'h3, "unmapped");
    bus(1, 8'h10, 8'hFF);
    chk(r, 32'h3, "unmapped write");
    bus(1, 8'hB7, 8'h00);
    bus(1, 8'hB8, 8'h00);
    // Random level sources; lowest polling index offered
    repeat (6) begin
      s = $urandom % 15 + 1;
      req = 10'h0;
      {req[3], req[7], req[8], req[1]} = s;
      srcs(14'h3000 | {8'h0, s[3:1], 2'h0, s[0]});
      repeat (3) @(posedge core_clk);
      chk(core_request, {2'b10, pick(req)}, "poll");
    end
    bus(1, 8'hB7, 8'h01);
    repeat (3) @(posedge core_clk);
    chk(core_request, {1'b1, s[2], s[2] ? 4'h7 : pick(req)}, "lvl");
    bus(1, 8'hA8, 8'h3F);
    repeat (3) @(posedge core_clk);
    chk(core_request.valid, 1'b0, "global");
    srcs(14'h3000);
    // Edge A, timer A and timer C vectored by the core
    bus(1, 8'h88, 8'h01);
    bus(1, 8'hC2, 8'h02);
    bus(1, 8'hA8, 8'hA3);
    run <= 1'b1;
    srcs(14'h1480);
    @(posedge core_clk);
    srcs(14'h3000);
    repeat (40) @(posedge core_clk);
    run <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(irq, 1'b1, "irq");
    bus(0, 8'h88, 8'h00);
    chk(q, 32'h1, "edge flag");
    chk(q & 32'h20, 32'h0, "timer a flag");
    bus(0, 8'hC8, 8'h00);
    chk(q, 32'h80, "timer c flag");
    bus(1, 8'hC8, 8'h00);
    bus(1, 8'hC1, 8'h02);
    bus(0, 8'hC8, 8'h00);
    chk({q[30:0], irq}, 32'h0, "cleared");
    // Converter on line B, mode 3 overflow, trigger pin falling edge
    bus(1, 8'hC0, 8'h01);
    bus(1, 8'hC8, 8'h08);
    srcs(14'h3E40);
    @(posedge core_clk);
    srcs(14'h3800);
    bus(0, 8'h88, 8'h00);
    chk(q, 32'h9, "takeover");
    chk(q & 32'h20, 32'h0, "mode 3");
    bus(0, 8'hC8, 8'h00);
    chk(q, 32'h48, "trigger");
    close_out();
  end
endmodule
